// [src/lcsi_status_indicators.sv]
// Purpose: LED and segment display driver for a safety light curtain.
// Assumes: State inputs come from logic on clk; keys are pins.
// Notes:   Registers over Avalon-MM with one wait cycle per access.
//
// Chosen here: the Avalon-MM register port and the address map.
`default_nettype none
module lcsi_status_indicators
  import lcsi_pkg::*;
#(
  parameter int unsigned STRENGTH_LEN = STRENGTH_CYC,
  parameter int unsigned FEEDBACK_LEN = FEEDBACK_CYC,
  parameter int unsigned BLINK_LEN    = BLINK_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        safetySwitchOutput,
  input  wire logic        restartInhibit,
  input  wire logic        intrusion,
  input  wire logic        ackSeen,
  input  wire logic        beamsOk,
  input  wire logic        beamWeak,
  input  wire logic        errActive,
  input  wire logic        syncOk,
  input  wire logic [3:0]  sigLevel,
  input  wire logic        mutingOn,
  input  wire logic        mutingSensorA,
  input  wire logic        mutingSensorB,
  input  wire logic        mutingSensorC,
  input  wire logic        mutingSensorD,
  input  wire logic        beltStop,
  input  wire logic        fullMutingEnable,
  input  wire logic        mutErr,
  input  wire logic [7:0]  mutErrCode,
  input  wire logic        warnValid,
  input  wire logic [7:0]  warnCode,
  input  wire logic        keyApplyPin,
  input  wire logic        keyUpPin,
  input  wire logic        keyDownPin,
  output var  logic        safetyLedFirst,
  output var  logic        safetyLedSecond,
  output var  logic        restartInhibitLed,
  output var  logic        weakSignalLed,
  output var  logic        rxErrorLed,
  output var  logic        emPowerLed,
  output var  logic        emCodingLed,
  output var  logic        longRangeLed,
  output var  logic        emErrorLed,
  output var  logic [31:0] dispSeg
);

  // Hex digit to seven-segment pattern.
  function automatic logic [7:0] hexSeg(input logic [3:0] v);
    case (v)
      4'h0: hexSeg = 8'h3F;
      4'h1: hexSeg = 8'h06;
      4'h2: hexSeg = 8'h5B;
      4'h3: hexSeg = 8'h4F;
      4'h4: hexSeg = 8'h66;
      4'h5: hexSeg = 8'h6D;
      4'h6: hexSeg = 8'h7D;
      4'h7: hexSeg = 8'h07;
      4'h8: hexSeg = 8'h7F;
      4'h9: hexSeg = 8'h6F;
      4'hA: hexSeg = 8'h77;
      4'hB: hexSeg = 8'h7C;
      4'hC: hexSeg = 8'h39;
      4'hD: hexSeg = 8'h5E;
      4'hE: hexSeg = 8'h79;
      default: hexSeg = 8'h71;
    endcase
  endfunction : hexSeg

  logic [6:0]  ctrl;
  logic [2:0]  kMeta;
  logic [2:0]  kSync;
  logic [2:0]  kPrev;
  lcsi_state_t st;
  logic [2:0]  menuIdx;
  logic [31:0] fbCnt;
  logic [31:0] strCnt;
  logic        strDone;
  logic [31:0] blinkCnt;
  logic        blinkPh;
  logic        synced;
  logic        occupied;
  logic        cancelled;
  logic        exitReq;
  logic        inA;
  logic        inB;
  logic        inC;
  logic        inD;
  logic        effActive;
  logic        blinkCond;
  logic [7:0]  mutDigit;
  logic [31:0] next_disp;
  logic        accept;

  // Bus handshake: one wait cycle, then the request is accepted.
  assign accept = (read | write) & ~waitrequest;

  // Keys come from pins and pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (srst) begin
      kMeta <= 3'h0;
      kSync <= 3'h0;
      kPrev <= 3'h0;
    end else if (ce) begin
      kMeta <= {keyDownPin, keyUpPin, keyApplyPin};
      kSync <= kMeta;
      kPrev <= kSync;
    end
  end

  // Waitrequest drops for one cycle per request; read data is set with it.
  always_ff @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        if (address == REG_CTRL) begin
          readdata <= {25'h0, ctrl};
        end else if (address == REG_STATUS) begin
          readdata <= {19'h0, st == ST_SUB, menuIdx, 3'(st), cancelled, rxErrorLed,
                       weakSignalLed, restartInhibitLed, safetyLedSecond, safetyLedFirst};
        end else if (address == REG_DISP) begin
          readdata <= dispSeg;
        end else begin
          readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Control register and the menu exit command.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl    <= CTRL_RESET;
      exitReq <= 1'b0;
    end else if (ce) begin
      exitReq <= 1'b0;
      if (accept & write) begin
        if (address == REG_CTRL) begin
          ctrl <= writedata[6:0];
        end else if (address == REG_CMD) begin
          exitReq <= writedata[CMD_EXIT];
        end
      end
    end
  end

  // Selects what drives each muting input segment.
  always_comb begin
    if (ctrl[CTRL_VARIANT +: 2] == VAR_SENSOR) begin
      inA = mutingSensorC;
    end else if (ctrl[CTRL_VARIANT +: 2] == VAR_BELT) begin
      inA = beltStop;
    end else begin
      inA = fullMutingEnable;
    end
    inB = mutingSensorD;
    inC = mutingSensorA;
    inD = mutingSensorB;
  end

  // Cross muting ends once the field clears after being occupied.
  always_ff @(posedge clk) begin
    if (srst) begin
      occupied  <= 1'b0;
      cancelled <= 1'b0;
    end else if (ce) begin
      occupied <= mutingOn & intrusion;
      if (ctrl[CTRL_CANCEL] & mutingOn & occupied & ~intrusion) begin
        cancelled <= 1'b1;
      end else if (~inC & ~inD) begin
        cancelled <= 1'b0;
      end
    end
  end
  // Muting counts as active unless cross muting was cancelled.
  assign effActive = mutingOn & ~cancelled;
  // Rightmost digit: input segments and the active mark.
  always_comb begin
    mutDigit = SEG_BLANK;
    if (inA & ~cancelled) mutDigit = mutDigit | SEG_INA;
    if (inB & ~cancelled) mutDigit = mutDigit | SEG_INB;
    if (inC) mutDigit = mutDigit | SEG_INC;
    if (inD) mutDigit = mutDigit | SEG_IND;
    if (effActive) mutDigit = mutDigit | SEG_ACT;
  end

  // Power-on strength window and synchronization marker.
  always_ff @(posedge clk) begin
    if (srst) begin
      strCnt  <= 32'h0000_0000;
      strDone <= 1'b0;
      synced  <= 1'b0;
    end else if (ce) begin
      if (!strDone) begin
        if (strCnt == STRENGTH_LEN - 1) begin
          strDone <= 1'b1;
        end
        strCnt <= strCnt + 32'h0000_0001;
      end
      if (syncOk) begin
        synced <= 1'b1;
      end
    end
  end

  // Key sequence for the configuration view, in any run or error state.
  always_ff @(posedge clk) begin
    if (srst) begin
      st      <= ST_IDLE;
      fbCnt   <= 32'h0000_0000;
      menuIdx <= 3'h0;
    end else if (ce) begin
      case (st)
        ST_IDLE: begin
          fbCnt <= 32'h0000_0000;
          if (kSync[0] & ~kPrev[0]) begin
            st <= ST_FEEDBACK;
          end
        end
        ST_FEEDBACK: begin
          if (!kSync[0]) begin
            st <= ST_IDLE;
          end else if (fbCnt == FEEDBACK_LEN - 1) begin
            st <= ST_WAITREL;
          end else begin
            fbCnt <= fbCnt + 32'h0000_0001;
          end
        end
        ST_WAITREL: begin
          if (!kSync[0]) begin
            st <= ST_MENU;
          end
        end
        ST_MENU: begin
          if (exitReq) begin
            st <= ST_IDLE;
          end else if (kSync[0] & ~kPrev[0]) begin
            st <= ST_SUB;
          end else if (kSync[1] & ~kPrev[1]) begin
            menuIdx <= (menuIdx == MENU_ENTRIES - 3'h1) ? 3'h0 : menuIdx + 3'h1;
          end else if (kSync[2] & ~kPrev[2]) begin
            menuIdx <= (menuIdx == 3'h0) ? MENU_ENTRIES - 3'h1 : menuIdx - 3'h1;
          end
        end
        ST_SUB: begin
          if (exitReq) begin
            st <= ST_IDLE;
          end else if (kSync[0] & ~kPrev[0]) begin
            st <= ST_MENU;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
  // Blinking is allowed only with inhibit set, outputs off, field clear and no ack.
  assign blinkCond = restartInhibit & ~safetySwitchOutput & ~intrusion & ~ackSeen;
  // Blink phase runs only while the blink condition holds.
  always_ff @(posedge clk) begin
    if (srst) begin
      blinkCnt <= 32'h0000_0000;
      blinkPh  <= 1'b0;
    end else if (ce) begin
      if (!blinkCond) begin
        blinkCnt <= 32'h0000_0000;
        blinkPh  <= 1'b0;
      end else if (blinkCnt == BLINK_LEN - 1) begin
        blinkCnt <= 32'h0000_0000;
        blinkPh  <= ~blinkPh;
      end else begin
        blinkCnt <= blinkCnt + 32'h0000_0001;
      end
    end
  end

  // Display content by priority: menu, muting error, strength, warning, muting, sync.
  always_comb begin
    next_disp = {4{SEG_BLANK}};
    if (st == ST_MENU || st == ST_SUB) begin
      next_disp = {hexSeg({1'b0, menuIdx}), hexSeg({3'h0, st == ST_SUB}), SEG_BLANK, SEG_MENU};
    end else if (mutErr) begin
      next_disp = {mutDigit, hexSeg(mutErrCode[3:0]), hexSeg(mutErrCode[7:4]), SEG_MERR};
    end else if (!strDone) begin
      next_disp = {hexSeg(sigLevel), {3{SEG_BLANK}}};
    end else if (warnValid) begin
      next_disp = {mutDigit, hexSeg(warnCode[3:0]), hexSeg(warnCode[7:4]), SEG_WARN};
    end else if (ctrl[CTRL_MUTCFG]) begin
      next_disp = {mutDigit, {3{synced ? SEG_SYNC : SEG_BLANK}}};
    end else if (synced) begin
      next_disp = {4{SEG_SYNC}};
    end
  end

  // Receiver LEDs and display, all registered.
  always_ff @(posedge clk) begin
    if (srst) begin
      safetyLedFirst    <= 1'b1;
      safetyLedSecond   <= 1'b0;
      restartInhibitLed <= 1'b0;
      weakSignalLed     <= 1'b0;
      rxErrorLed        <= 1'b0;
      dispSeg           <= 32'h0000_0000;
    end else if (ce) begin
      safetyLedFirst    <= ~safetySwitchOutput;
      safetyLedSecond   <= safetySwitchOutput;
      restartInhibitLed <= blinkCond & blinkPh;
      if (st == ST_FEEDBACK) begin
        weakSignalLed <= 1'b1;
      end else begin
        weakSignalLed <= safetySwitchOutput & beamsOk & beamWeak;
      end
      rxErrorLed <= errActive;
      dispSeg    <= next_disp;
    end
  end

  // Emitter LEDs.
  always_ff @(posedge clk) begin
    if (srst) begin
      emPowerLed   <= 1'b0;
      emCodingLed  <= 1'b0;
      longRangeLed <= 1'b0;
      emErrorLed   <= 1'b0;
    end else if (ce) begin
      emPowerLed   <= ctrl[CTRL_POWER];
      emCodingLed  <= ctrl[CTRL_CODING];
      longRangeLed <= ctrl[CTRL_RANGE];
      emErrorLed   <= errActive;
    end
  end

  // Checks.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_safe_off;
    ce && !safetySwitchOutput |=> safetyLedFirst && !safetyLedSecond;
  endproperty
  a_safe_off: assert property (p_safe_off) else $error("Safety LEDs wrong with outputs off.");
  property p_safe_on;
    ce && safetySwitchOutput |=> !safetyLedFirst && safetyLedSecond;
  endproperty
  a_safe_on: assert property (p_safe_on) else $error("Safety LEDs wrong with outputs on.");

  property p_blink;
    ce && !blinkCond |=> !restartInhibitLed;
  endproperty
  a_blink: assert property (p_blink) else $error("Restart LED lit without cause.");

  property p_weak_on;
    ce && safetySwitchOutput && beamsOk && beamWeak |=> weakSignalLed;
  endproperty
  a_weak_on: assert property (p_weak_on) else $error("Weak-signal LED dark with weak beam.");

  property p_weak_off;
    ce && !safetySwitchOutput && st != ST_FEEDBACK |=> !weakSignalLed;
  endproperty
  a_weak_off: assert property (p_weak_off) else $error("Weak-signal LED lit with outputs off.");

  property p_err;
    ce ##1 1'b1 |-> rxErrorLed == $past(errActive);
  endproperty
  a_err: assert property (p_err) else $error("Error LED does not follow errors.");

  property p_fb;
    ce && st == ST_FEEDBACK |=> weakSignalLed;
  endproperty
  a_fb: assert property (p_fb) else $error("Feedback light dark while apply is held.");

  property p_menu;
    ce && st == ST_WAITREL && !kSync[0] && !exitReq |=> st == ST_MENU;
  endproperty
  a_menu: assert property (p_menu) else $error("Menu not shown after key release.");

  property p_merr;
    ce && mutErr && st == ST_IDLE |=> dispSeg[7:0] == SEG_MERR;
  endproperty
  a_merr: assert property (p_merr) else $error("Muting error letter missing.");

  property p_cancel;
    ce && cancelled |=> !dispSeg[31] || !$past(ctrl[CTRL_MUTCFG]) || $past(st) != ST_IDLE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("Active mark shown after cancel.");

  c_feedback: cover property (st == ST_FEEDBACK ##1 st == ST_WAITREL);
  c_menu: cover property (st == ST_MENU ##1 st == ST_SUB);
  c_cancel: cover property ($rose(cancelled));
  c_blink: cover property ($rose(restartInhibitLed));
endmodule : lcsi_status_indicators
`default_nettype wire

// [src/lcsi_pkg.sv]
// Purpose: Constants and types for the light curtain status indicator block.
// Assumes: 100 MHz clock; segment bit order a,b,c,d,e,f,g,dp from bit 0.
`default_nettype none
package lcsi_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STRENGTH_S = 30;
  localparam int unsigned FEEDBACK_S = 2;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned STRENGTH_CYC = STRENGTH_S * CLK_HZ;
  localparam int unsigned FEEDBACK_CYC = FEEDBACK_S * CLK_HZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam logic [2:0] MENU_ENTRIES = 3'h7;
  // Register byte offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DISP = 4'hC;
  // Control field positions and reset value.
  localparam int CTRL_VARIANT = 0;
  localparam int CTRL_CANCEL = 2;
  localparam int CTRL_MUTCFG = 3;
  localparam int CTRL_CODING = 4;
  localparam int CTRL_RANGE = 5;
  localparam int CTRL_POWER = 6;
  localparam logic [6:0] CTRL_RESET = 7'h48;
  localparam int CMD_EXIT = 0;
  // Muting variants for the first muting input.
  localparam logic [1:0] VAR_SENSOR = 2'h0;
  localparam logic [1:0] VAR_BELT = 2'h1;
  // Segment patterns.
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_MERR = 8'h37;
  localparam logic [7:0] SEG_SYNC = 8'h80;
  localparam logic [7:0] SEG_WARN = 8'h3E;
  localparam logic [7:0] SEG_MENU = 8'h54;
  localparam logic [7:0] SEG_INA = 8'h20;
  localparam logic [7:0] SEG_INB = 8'h02;
  localparam logic [7:0] SEG_INC = 8'h10;
  localparam logic [7:0] SEG_IND = 8'h04;
  localparam logic [7:0] SEG_ACT = 8'h80;
  typedef enum logic [2:0] {ST_IDLE, ST_FEEDBACK, ST_WAITREL, ST_MENU, ST_SUB} lcsi_state_t;
endpackage : lcsi_pkg
`default_nettype wire

// [testbench/lcsi_operator.sv]
// Purpose: Operator model that presses the keys and watches the feedback LED.
// Assumes: Keys read high when pressed; pins change right after a rising edge.
// Notes:   Presses last long enough to pass the key synchronizer.
`default_nettype none
module lcsi_operator (
  input  wire logic clk,
  input  wire logic weakSignalLed,
  output var  logic keyApplyPin,
  output var  logic keyUpPin,
  output var  logic keyDownPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // All keys start released.
  initial begin
    keyApplyPin = 1'b0;
    keyUpPin = 1'b0;
    keyDownPin = 1'b0;
  end
  // Holds apply until the feedback light has come and gone, then lets go.
  task automatic hold_apply(output int lit);
    int n;
    n = 0;
    lit = 0;
    keyApplyPin <= 1'b1;
    while (weakSignalLed !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    while (weakSignalLed === 1'b1 && lit < 100) begin
      @(posedge clk);
      lit++;
    end
    keyApplyPin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : hold_apply
  // Short press of one key: 0 apply, 1 up, 2 down.
  task automatic tap(input int k);
    if (k == 0) keyApplyPin <= 1'b1;
    else if (k == 1) keyUpPin <= 1'b1;
    else keyDownPin <= 1'b1;
    repeat (4) @(posedge clk);
    keyApplyPin <= 1'b0;
    keyUpPin <= 1'b0;
    keyDownPin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tap
endmodule : lcsi_operator
`default_nettype wire

// [testbench/lcsi_status_indicators_bench.sv]
// Purpose: Self-checking bench for the light curtain status indicators.
// Assumes: Shortened counts; values are read at rising edges before they update.
// Notes:   Digit patterns follow the common hex encoding.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t: got %h want %h", $time, g, e); end end
module lcsi_status_indicators_bench import lcsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] HX [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
                                     8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  int          failures, check_count, lit;
  logic        clk, srst, ce, read, write, waitrequest, safetySwitchOutput, restartInhibit, intrusion;
  logic        ackSeen, beamsOk, beamWeak, errActive, syncOk, mutingOn, beltStop, fullMutingEnable;
  logic        mutingSensorA, mutingSensorB, mutingSensorC, mutingSensorD, mutErr, warnValid;
  logic        keyApplyPin, keyUpPin, keyDownPin, safetyLedFirst, safetyLedSecond, restartInhibitLed;
  logic        weakSignalLed, rxErrorLed, emPowerLed, emCodingLed, longRangeLed, emErrorLed;
  logic [3:0]  address, sigLevel;
  logic [7:0]  mutErrCode, warnCode;
  logic [31:0] writedata, readdata, dispSeg, rd;
  lcsi_status_indicators #(.STRENGTH_LEN(200), .FEEDBACK_LEN(20), .BLINK_LEN(5)) lcsi_status_indicators_i (
    .clk, .srst, .ce, .address, .read, .write, .writedata, .readdata, .waitrequest, .safetySwitchOutput,
    .restartInhibit, .intrusion, .ackSeen, .beamsOk, .beamWeak, .errActive, .syncOk, .sigLevel, .mutingOn,
    .mutingSensorA, .mutingSensorB, .mutingSensorC, .mutingSensorD, .beltStop, .fullMutingEnable, .mutErr,
    .mutErrCode, .warnValid, .warnCode, .keyApplyPin, .keyUpPin, .keyDownPin, .safetyLedFirst,
    .safetyLedSecond, .restartInhibitLed, .weakSignalLed, .rxErrorLed, .emPowerLed, .emCodingLed,
    .longRangeLed, .emErrorLed, .dispSeg);
  lcsi_operator lcsi_operator_i (.clk, .weakSignalLed, .keyApplyPin, .keyUpPin, .keyDownPin);
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  // Waits n rising edges.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // One Avalon transfer, held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) begin
      failures++;
      $display("[ERR] %0t: bus hang", $time);
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  // State straight after reset, including the register bus.
  task automatic t_reset();
    step(4);
    `CHK({safetyLedFirst, safetyLedSecond, weakSignalLed, rxErrorLed}, 4'b1000)
    `CHK(dispSeg[31:24], HX[5])
    `CHK(emPowerLed, 1'b1)
    bus(1'b0, REG_CTRL, '0);
    `CHK(rd, {25'h0, CTRL_RESET})
    bus(1'b0, 4'h1, '0);
    `CHK(rd, 32'h0)
  endtask : t_reset
  // Safety LEDs and the weak-signal LED, including forcing dark.
  task automatic t_safety();
    {beamsOk, beamWeak, safetySwitchOutput} <= 3'b111;
    step(3);
    `CHK({safetyLedFirst, safetyLedSecond, weakSignalLed}, 3'b011)
    beamsOk <= 1'b0;
    step(3);
    `CHK(weakSignalLed, 1'b0)
    {beamsOk, beamWeak} <= 2'b10;
    step(3);
    `CHK(weakSignalLed, 1'b0)
    {beamWeak, safetySwitchOutput} <= 2'b10;
    step(3);
    `CHK({safetyLedFirst, safetyLedSecond, weakSignalLed}, 3'b100)
  endtask : t_safety
  // Blinking only when every condition holds; ack, intrusion and outputs on each tried in turn as a blocker.
  task automatic t_restart();
    int hi;
    restartInhibit <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      ackSeen <= (k == 1);
      intrusion <= (k == 2);
      safetySwitchOutput <= (k == 3);
      step(3);
      hi = 0;
      repeat (20) begin
        step(1);
        hi += (restartInhibitLed === 1'b1);
      end
      `CHK(hi, (k == 0) ? 10 : 0)
    end
    {restartInhibit, ackSeen, intrusion, safetySwitchOutput} <= '0;
  endtask : t_restart
  // Error LEDs and the emitter LEDs set from the control register.
  task automatic t_leds();
    errActive <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h38);
    step(2);
    `CHK({rxErrorLed, emErrorLed, emPowerLed, emCodingLed, longRangeLed}, 5'b11011)
    errActive <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h48);
    step(2);
    `CHK({rxErrorLed, emErrorLed, emPowerLed, emCodingLed, longRangeLed}, 5'b00100)
  endtask : t_leds
  // End of the strength window, then the synchronization marker.
  task automatic t_display();
    step(200);
    `CHK(dispSeg, 32'h0)
    syncOk <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h40);
    syncOk <= 1'b0;
    step(2);
    `CHK(dispSeg, 32'h80808080)
    bus(1'b1, REG_CTRL, 32'h48);
    step(2);
    `CHK(dispSeg, 32'h00808080)
  endtask : t_display
  // Muting digit for every variant, active muting and cancelled cross muting.
  task automatic t_muting();
    for (int v = 0; v < 3; v++) begin
      bus(1'b1, REG_CTRL, 32'h48 | v);
      for (int s = 0; s < 3; s++) begin
        {mutingSensorC, beltStop, fullMutingEnable} <= 3'b100 >> s;
        step(3);
        `CHK(dispSeg[31:24], (s == v) ? SEG_INA : SEG_BLANK)
      end
    end
    {mutingSensorC, beltStop, fullMutingEnable} <= '0;
    bus(1'b1, REG_CTRL, 32'h4C);
    {mutingSensorC, mutingSensorD, mutingOn} <= 3'b111;
    step(3);
    `CHK(dispSeg[31:24], SEG_INA | SEG_INB | SEG_ACT)
    {mutingSensorA, mutingSensorB, intrusion} <= 3'b111;
    step(3);
    `CHK(dispSeg[31:24], 8'hB6)
    intrusion <= 1'b0;
    step(3);
    `CHK(dispSeg[31:24], SEG_INC | SEG_IND)
    {mutingSensorA, mutingSensorB, mutingSensorC, mutingSensorD, mutingOn} <= '0;
  endtask : t_muting
  // Muting error and warning codes.
  task automatic t_codes();
    {mutErr, mutErrCode} <= {1'b1, 8'h3A};
    step(3);
    `CHK(dispSeg, {8'h00, HX[10], HX[3], SEG_MERR})
    {mutErr, warnValid, warnCode} <= {1'b0, 1'b1, 8'h21};
    step(3);
    `CHK(dispSeg, {8'h00, HX[1], HX[2], SEG_WARN})
    warnValid <= 1'b0;
  endtask : t_codes
  // Configuration view from the error state, menu walk with wrap, submenu, exit.
  task automatic t_menu();
    errActive <= 1'b1;
    lcsi_operator_i.hold_apply(lit);
    `CHK(lit inside {[19:21]}, 1'b1)
    step(2);
    `CHK({dispSeg[31:16], dispSeg[7:0]}, {HX[0], HX[0], SEG_MENU})
    lcsi_operator_i.tap(1);
    `CHK(dispSeg[31:24], HX[1])
    lcsi_operator_i.tap(2);
    lcsi_operator_i.tap(2);
    `CHK(dispSeg[31:24], HX[6])
    lcsi_operator_i.tap(0);
    `CHK(dispSeg[23:16], HX[1])
    lcsi_operator_i.tap(0);
    `CHK(dispSeg[23:16], HX[0])
    bus(1'b1, REG_CMD, 32'h1);
    step(2);
    `CHK(dispSeg, 32'h00808080)
    errActive <= 1'b0;
  endtask : t_menu
  // Clock enable freezes all state; a mid-run reset brings back the power-on view.
  task automatic t_freeze_reset();
    ce <= 1'b0;
    safetySwitchOutput <= 1'b1;
    step(3);
    `CHK({safetyLedFirst, safetyLedSecond}, 2'b10)
    ce <= 1'b1;
    step(2);
    `CHK({safetyLedFirst, safetyLedSecond}, 2'b01)
    {safetySwitchOutput, sigLevel, srst} <= {1'b0, 4'hC, 1'b1};
    step(3);
    srst <= 1'b0;
    step(2);
    `CHK({waitrequest, safetyLedFirst, dispSeg}, {1'b1, 1'b1, HX[12], 24'h0})
    bus(1'b0, REG_STATUS, '0);
    `CHK(rd, 32'h0000_0001)
    bus(1'b0, REG_DISP, '0);
    `CHK(rd, {HX[12], 24'h0})
  endtask : t_freeze_reset
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence: quiet inputs, reset for three cycles, then each scenario.
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    sigLevel = 4'h5;
    {read, write, address, writedata} = '0;
    {safetySwitchOutput, restartInhibit, intrusion, ackSeen, beamsOk, beamWeak, errActive, syncOk} = '0;
    {mutingOn, mutingSensorA, mutingSensorB, mutingSensorC, mutingSensorD, beltStop, fullMutingEnable} = '0;
    {mutErr, mutErrCode, warnValid, warnCode} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_safety();
    t_restart();
    t_leds();
    t_display();
    t_muting();
    t_codes();
    t_menu();
    t_freeze_reset();
    tally_and_finish();
  end
  // Cuts a hung run short; the tests need well under 20 us.
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : lcsi_status_indicators_bench
`default_nettype wire
